/* File: phone_port_regs.vh */
// Constants for the telephone controller parallel port block
`ifndef PHONE_PORT_REGS_VH
`define PHONE_PORT_REGS_VH

// Port select codes for input and output instructions
`define PORT_KEY_A        3'h0
`define PORT_KEY_B        3'h1
`define PORT_GATED        3'h2
`define PORT_HOOK         3'h3
`define PORT_HOOK_OUT     3'h4
`define PORT_GENERAL      3'h5
`define PORT_EXTRA        3'h6
`define PORT_BIDIR        3'h7

// Reset values of output latches
`define HOOK_OUT_RESET    4'h0
`define GENERAL_RESET     4'hc
`define EXTRA_RESET       4'h0
`define BIDIR_RESET       4'h0

// Clock divider
`define CLK_DIVIDE        112
`define CLK_HALF          56

`endif

/* File: phone_mcu_port_block.v */
// Parallel port block of a 4-bit telephone controller
// Behaviour
// R1 - Two 4-bit pulled-down key input nibbles are read by input instructions.
// R2 - Gated input pull-down connects only while read or while input already low.
// R3 - Hook switch input is pulled up and readable by input instruction.
// R4 - Hook-gated output nibble drives its latch; latch clears at reset.
// R5 - Hook switch open or high forces hook-gated outputs low.
// R6 - General output nibble drives a latch written by output instructions.
// R7 - General latch resets with bits 0,1 cleared and bits 2,3 set.
// R8 - Extra output nibble drives a written latch, defined after reset.
// R9 - Extra output nibble resets low on all pins.
// R10 - Bidirectional nibble readable, writable, driving pins only in output mode.
// R11 - Strobe pin pulses when bidirectional latch is written.
// R12 - Strobe pin pulses when bidirectional nibble is read.
// R13 - Divided clock is system clock over 112 at 50% duty.
// R14 - Divided clock runs continuously with no software control.
`timescale 1ns/1ps
`include "phone_port_regs.vh"

module phone_mcu_port_block #(
    parameter DIVIDE = `CLK_DIVIDE
) (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Core instruction port
    input  wire       inStrobe,
    input  wire       outStrobe,
    input  wire [2:0] portSel,
    input  wire [3:0] writeData,
    input  wire       bidirOutMode,
    output reg  [3:0] readData,
    // Input pins
    input  wire [3:0] keyInputNibbleA,
    input  wire [3:0] keyInputNibbleB,
    input  wire [3:0] gatedPulldownInput,
    output wire [3:0] gatedPulldownEnable,
    input  wire       hookSwitchInput,
    // Output pins
    output wire [3:0] hookGatedOutput,
    output wire [3:0] generalOutputNibble,
    output wire [3:0] extraOutputNibble,
    // Bidirectional pins
    input  wire [3:0] bidirNibbleIn,
    output wire [3:0] bidirNibbleOut,
    output wire [3:0] bidirNibbleOe,
    output reg        bidirStrobePin,
    // Divided clock
    output reg        dividedClockOut
);

    localparam        NUM_PINS = 17;
    localparam        HOOK_BIT = 12;
    localparam [31:0] HALF_W   = DIVIDE / 2;
    localparam [6:0]  HALF     = HALF_W[6:0];

    // Pin synchronisers: three stages, change accepted when stages two and three agree
    reg  [NUM_PINS-1:0] sync1_q;
    reg  [NUM_PINS-1:0] sync2_q;
    reg  [NUM_PINS-1:0] sync3_q;
    reg  [NUM_PINS-1:0] pinState_q;
    wire [NUM_PINS-1:0] pinRaw;

    assign pinRaw = {bidirNibbleIn, hookSwitchInput, gatedPulldownInput,
                     keyInputNibbleB, keyInputNibbleA};

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i = i + 1)
        begin : g_sync
            // Idle level: hook pin pulled up, all others pulled down
            localparam [0:0] IDLE = (i == HOOK_BIT) ? 1'b1 : 1'b0;

            always @(posedge clk)
            begin
                if (reset)
                begin
                    sync1_q[i]    <= IDLE;
                    sync2_q[i]    <= IDLE;
                    sync3_q[i]    <= IDLE;
                    pinState_q[i] <= IDLE;
                end
                else
                begin
                    sync1_q[i] <= pinRaw[i];
                    sync2_q[i] <= sync1_q[i];
                    sync3_q[i] <= sync2_q[i];
                    if (sync2_q[i] == sync3_q[i])
                        pinState_q[i] <= sync3_q[i];
                end
            end
        end
    endgenerate

    // Synchronised pin levels
    wire [3:0] keyA;
    wire [3:0] keyB;
    wire [3:0] gated;
    wire       hookHigh;
    wire [3:0] bidirIn;

    assign keyA     = pinState_q[3:0];
    assign keyB     = pinState_q[7:4];
    assign gated    = pinState_q[11:8];
    assign hookHigh = pinState_q[HOOK_BIT];
    assign bidirIn  = pinState_q[16:13];

    // Instruction decode
    wire readGated;
    wire writeHook;
    wire writeGeneral;
    wire writeExtra;
    wire bidirWrite;
    wire bidirRead;

    assign readGated    = inStrobe  && (portSel == `PORT_GATED);
    assign writeHook    = outStrobe && (portSel == `PORT_HOOK_OUT);
    assign writeGeneral = outStrobe && (portSel == `PORT_GENERAL);
    assign writeExtra   = outStrobe && (portSel == `PORT_EXTRA);
    assign bidirWrite   = outStrobe && (portSel == `PORT_BIDIR);
    assign bidirRead    = inStrobe  && (portSel == `PORT_BIDIR);

    // Output latches
    reg  [3:0] hookOut_q;
    wire [3:0] hookOut_d;
    reg  [3:0] hookGated_q;
    reg  [3:0] general_q;
    reg  [3:0] extra_q;
    reg  [3:0] bidir_q;
    reg        bidirOe_q;
    reg  [6:0] divCount_q;

    assign hookOut_d = writeHook ? writeData : hookOut_q;                // R4

    // Hook-gated latch and pin register
    always @(posedge clk)
    begin
        if (reset)
        begin
            hookOut_q   <= `HOOK_OUT_RESET;                              // R4
            hookGated_q <= `HOOK_OUT_RESET;                              // R4
        end
        else
        begin
            hookOut_q   <= hookOut_d;                                    // R4
            hookGated_q <= hookHigh ? 4'h0 : hookOut_d;                  // R5
        end
    end

    // General output latch
    always @(posedge clk)
    begin
        if (reset)
            general_q <= `GENERAL_RESET;                                 // R7
        else if (writeGeneral)
            general_q <= writeData;                                      // R6
    end

    // Extra output latch
    always @(posedge clk)
    begin
        if (reset)
            extra_q <= `EXTRA_RESET;                                     // R9
        else if (writeExtra)
            extra_q <= writeData;                                        // R8
    end

    // Bidirectional latch and direction
    always @(posedge clk)
    begin
        if (reset)
        begin
            bidir_q   <= `BIDIR_RESET;
            bidirOe_q <= 1'b0;
        end
        else if (bidirWrite)
        begin
            bidir_q   <= writeData;                                      // R10
            bidirOe_q <= bidirOutMode;                                   // R10
        end
    end

    // Strobe pulse on every access of the bidirectional nibble
    always @(posedge clk)
    begin
        if (reset)
            bidirStrobePin <= 1'b0;
        else
            bidirStrobePin <= bidirWrite | bidirRead;                    // R11 R12
    end

    // Read data register, held until the next input instruction
    always @(posedge clk)
    begin
        if (reset)
            readData <= 4'h0;
        else if (inStrobe)
        begin
            case (portSel)
                `PORT_KEY_A:
                    readData <= keyA;                                    // R1
                `PORT_KEY_B:
                    readData <= keyB;                                    // R1
                `PORT_GATED:
                    readData <= gated;                                   // R2
                `PORT_HOOK:
                    readData <= {3'h0, hookHigh};                        // R3
                `PORT_BIDIR:
                    readData <= bidirIn;                                 // R10
                default:
                    readData <= 4'h0;
            endcase
        end
    end

    // Free-running divider, no enable or stop
    always @(posedge clk)
    begin
        if (reset)
        begin
            divCount_q      <= 7'h00;
            dividedClockOut <= 1'b0;
        end
        else if (divCount_q == HALF - 7'h01)                             // R13
        begin
            divCount_q      <= 7'h00;
            dividedClockOut <= ~dividedClockOut;                         // R14
        end
        else
        begin
            divCount_q <= divCount_q + 7'h01;                            // R14
        end
    end

    // Pull-down connected during a read of the port, or while the pin is low
    assign gatedPulldownEnable = {4{readGated}} | ~gated;                // R2

    assign hookGatedOutput     = hookGated_q;                            // R5
    assign generalOutputNibble = general_q;                              // R6
    assign extraOutputNibble   = extra_q;                                // R8
    assign bidirNibbleOut      = bidir_q;                                // R10
    assign bidirNibbleOe       = {4{bidirOe_q}};                         // R10

endmodule // phone_mcu_port_block

/* File: phone_mcu_port_block_monitor.sv */
// Assertions on the telephone port block
`timescale 1ns/1ps
module phone_mcu_port_block_monitor #(parameter DIVIDE = 112) (
    input wire logic       clk, reset, inStrobe, outStrobe, bidirOutMode,
    input wire logic       hookSwitchInput, bidirStrobePin, dividedClockOut,
    input wire logic [2:0] portSel,
    input wire logic [3:0] writeData, hookGatedOutput, generalOutputNibble,
    input wire logic [3:0] extraOutputNibble, bidirNibbleOut, bidirNibbleOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence bidirWr; outStrobe && portSel == 3'h7; endsequence
    sequence bidirRd; inStrobe && portSel == 3'h7; endsequence
    logic [6:0] n;
    logic       s, q;
    always_ff @(posedge clk)
    begin
        q <= dividedClockOut;
        n <= (reset || dividedClockOut != q) ? 7'h1 : n + 7'h1;
        s <= reset ? 1'b0 : (s || dividedClockOut != q);
    end
    strobe_on_write_a: assert property (bidirWr |=> bidirStrobePin)
        else $error("no strobe after bidir write");
    strobe_on_read_a: assert property (bidirRd |=> bidirStrobePin)
        else $error("no strobe after bidir read");
    hook_forces_low_a: assert property (hookSwitchInput[*6] |-> hookGatedOutput == 4'h0)
        else $error("hook outputs not forced low");
    general_write_a: assert property (outStrobe && portSel == 3'h5 |=>
        generalOutputNibble == $past(writeData)) else $error("general latch wrong");
    extra_write_a: assert property (outStrobe && portSel == 3'h6 |=>
        extraOutputNibble == $past(writeData)) else $error("extra latch wrong");
    bidir_write_a: assert property (bidirWr |=> bidirNibbleOut == $past(writeData)
        && bidirNibbleOe == {4{$past(bidirOutMode)}}) else $error("bidir latch wrong");
    reset_values_a: assert property ($fell(reset) |-> generalOutputNibble == 4'hc
        && extraOutputNibble == 4'h0 && hookGatedOutput == 4'h0) else $error("bad reset");
    divider_half_a: assert property ($changed(dividedClockOut) && s |-> n == DIVIDE / 2)
        else $error("divided clock half period wrong");
endmodule // phone_mcu_port_block_monitor
bind phone_mcu_port_block phone_mcu_port_block_monitor #(.DIVIDE(DIVIDE)) u_mon (
    .clk(clk), .reset(reset), .inStrobe(inStrobe), .outStrobe(outStrobe),
    .bidirOutMode(bidirOutMode), .hookSwitchInput(hookSwitchInput),
    .bidirStrobePin(bidirStrobePin), .dividedClockOut(dividedClockOut),
    .portSel(portSel), .writeData(writeData), .hookGatedOutput(hookGatedOutput),
    .generalOutputNibble(generalOutputNibble), .extraOutputNibble(extraOutputNibble),
    .bidirNibbleOut(bidirNibbleOut), .bidirNibbleOe(bidirNibbleOe));

/* File: phone_far_side.sv */
// Keypad, hook switch and bidirectional pin model
`timescale 1ns/1ps
module phone_far_side (
    input wire logic [3:0] keysA, keysB, tiedHigh, pinOut, pinOe, extDrive,
    input wire logic       offHook,
    output logic     [3:0] pinA, pinB, gatedPin, pinIn,
    output logic           hookPin
);
    assign pinA = keysA;
    assign pinB = keysB;
    assign gatedPin = tiedHigh;
    assign hookPin = !offHook;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule // phone_far_side

/* File: phone_mcu_port_block_tb.sv */
// Self-checking bench for the telephone port block
`timescale 1ns/1ps
`include "phone_port_regs.vh"
module phone_mcu_port_block_tb;
    logic clk = 0, reset = 1, inS = 0, outS = 0, mode = 1, offHook = 1;
    logic [2:0] sel = 3'h0;
    logic [3:0] wd = 4'h0, kA = 4'h5, kB = 4'ha, tie = 4'h3, ext = 4'h6;
    logic [3:0] rd, pA, pB, gP, pdEn, bIn, hgO, gO, eO, bO, bOe;
    logic hs, strobe, dco;
    int failures = 0, num_checks = 0, cyc = 0;
    // Rows: write flag and port, data, expected
    logic [11:0] rows [11] = '{12'h005, 12'h10a, 12'h400, 12'h203, 12'h300, 12'h706,
        12'hc99, 12'hd77, 12'heee, 12'hf55, 12'h705};
    always #12.5 clk = ~clk;
    phone_far_side u_far (.keysA(kA), .keysB(kB), .tiedHigh(tie), .pinOut(bO),
        .pinOe(bOe), .extDrive(ext), .offHook(offHook), .pinA(pA), .pinB(pB),
        .gatedPin(gP), .pinIn(bIn), .hookPin(hs));
    phone_mcu_port_block u_dut (.clk(clk), .reset(reset), .inStrobe(inS),
        .outStrobe(outS), .portSel(sel), .writeData(wd), .bidirOutMode(mode),
        .readData(rd), .keyInputNibbleA(pA), .keyInputNibbleB(pB),
        .gatedPulldownInput(gP), .gatedPulldownEnable(pdEn), .hookSwitchInput(hs),
        .hookGatedOutput(hgO), .generalOutputNibble(gO), .extraOutputNibble(eO),
        .bidirNibbleIn(bIn), .bidirNibbleOut(bO), .bidirNibbleOe(bOe),
        .bidirStrobePin(strobe), .dividedClockOut(dco));
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [3:0] seen(input logic [2:0] p);
        case (p)
            3'h4: seen = hgO;
            3'h5: seen = gO;
            3'h6: seen = eO;
            default: seen = bO;
        endcase
    endfunction
    task automatic op(input logic [11:0] r);
        @(negedge clk);
        {outS, sel} = r[11:8];
        inS = !r[11];
        wd = r[7:4];
        @(negedge clk);
        {inS, outS} = 2'b00;
        chk({3'h0, strobe}, {3'h0, r[10:8] == 3'h7});
        chk(r[11] ? seen(r[10:8]) : rd, r[3:0]);
        repeat (5) @(negedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            failures++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (12) @(negedge clk);
        reset = 0;
        chk(gO, 4'hc);
        chk(eO, 4'h0);
        chk(hgO, 4'h0);
        repeat (4) @(negedge clk);
        foreach (rows[i]) op(rows[i]);
        chk(pdEn, 4'hc);
        chk(bOe, 4'hf);
        offHook = 0;
        repeat (6) @(negedge clk);
        chk(hgO, 4'h0);
        inS = 1;
        sel = 3'h2;
        #1 chk(pdEn, 4'hf);
        @(negedge clk);
        inS = 0;
        offHook = 1;
        repeat (6) @(negedge clk);
        chk(hgO, 4'h9);
        reset = 1;
        repeat (2) @(negedge clk);
        reset = 0;
        chk(gO, 4'hc);
        chk(eO, 4'h0);
        chk(hgO, 4'h0);
        chk(bOe, 4'h0);
        chk(rd, 4'h0);
        chk({3'h0, strobe}, 4'h0);
        repeat (`CLK_HALF - 1) @(negedge clk);
        chk({3'h0, dco}, 4'h0);
        @(negedge clk);
        chk({3'h0, dco}, 4'h1);
        repeat (`CLK_HALF - 1) @(negedge clk);
        chk({3'h0, dco}, 4'h1);
        @(negedge clk);
        chk({3'h0, dco}, 4'h0);
        report_and_stop;
    end
endmodule // phone_mcu_port_block_tb
